// *** hdl/vpm_pkg.sv ***
// constants and register map of the vga planar memory path
// What this block does
// - four map mask bits gate writes to planes 3..0, with chain control
// - write mode 3 uses bit mask ANDed with rotated data, set/reset as data
// - write mode 2 takes each plane's fill value from its write data bit
// - outside write mode 2, the write byte is rotated right by the three-bit rotate count first
// - outside write modes 2 and 3, set/reset replaces a plane's data only where its enable bit is set
// - enabled planes get all ones or all zeros from their set/reset bit
// - bit mask picks new data per bit, else the display latch contents
// - read mode 0 unchained returns the plane named by read plane select
// - force bit set drives vga address bit 15 to zero
// - packed chain 4 with chain 4 shifts vga address right by two bits
// - chain 4 applies to reads and writes, overriding both chain 2 bits
// - odd/even chaining puts the page bit in the address lsb
// - write chain 2 without chain 4 selects chain 2 addressing for writes
// - read chain 2 without chain 4 selects chain 2 addressing for reads
// - read mode bit picks normal plane read or colour compare
// - colour compare only looks at planes set in the compare mask
// - each compared plane bit is checked against its compare colour bit
// - write window base adds into graphics memory address bits 19..14
// - display latch register reads and writes the live 32-bit latch
// - every vga read loads the latch; writes use the latch as data
package vpm_pkg;
   localparam logic [15:0] VPM_OFF_WRITE_CTL = 16'h8140;
   localparam logic [15:0] VPM_OFF_READ_CTL  = 16'h8144;
   localparam logic [15:0] VPM_OFF_BASE      = 16'h8210;
   localparam logic [15:0] VPM_OFF_LATCH     = 16'h8214;

   // write path control fields
   localparam int VPM_WR_MAP_LSB  = 24;
   localparam int VPM_WR_MODE3    = 20;
   localparam int VPM_WR_MODE2    = 19;
   localparam int VPM_WR_ROT_LSB  = 16;
   localparam int VPM_WR_SEN_LSB  = 12;
   localparam int VPM_WR_SVAL_LSB = 8;
   localparam int VPM_WR_MASK_LSB = 0;
   localparam logic [31:0] VPM_WR_USED = 32'h0f1fffff;

   // read path control fields
   localparam int VPM_RD_PLANE_LSB = 16;
   localparam int VPM_RD_FRC15     = 15;
   localparam int VPM_RD_PACK      = 14;
   localparam int VPM_RD_QUAD      = 13;
   localparam int VPM_RD_PAGE      = 12;
   localparam int VPM_RD_OE        = 11;
   localparam int VPM_RD_WCH2      = 10;
   localparam int VPM_RD_RCH2      = 9;
   localparam int VPM_RD_MODE      = 8;
   localparam int VPM_RD_CMSK_LSB  = 4;
   localparam int VPM_RD_CCOL_LSB  = 0;
   localparam logic [31:0] VPM_RD_USED = 32'h0003ffff;

   // window base fields
   localparam int VPM_BASE_RD_LSB = 8;
   localparam int VPM_BASE_WR_LSB = 0;
   localparam logic [31:0] VPM_BASE_USED = 32'h00003f3f;
   localparam int VPM_BASE_SHIFT  = 14;

   localparam logic [31:0] VPM_WRITE_CTL_RST = 32'h00000000;
   localparam logic [31:0] VPM_READ_CTL_RST  = 32'h00000000;
   localparam logic [31:0] VPM_BASE_RST      = 32'h00000000;
   localparam logic [31:0] VPM_LATCH_RST     = 32'h00000000;

   localparam logic [3:0] VPM_ALL_PLANES  = 4'hf;
   localparam logic [3:0] VPM_EVEN_PLANES = 4'h5;
   localparam logic [3:0] VPM_ODD_PLANES  = 4'ha;
   localparam logic [3:0] VPM_PLANE0      = 4'h1;

   typedef enum logic [1:0] {
      VPM_ST_IDLE = 2'b00,
      VPM_ST_WAIT = 2'b01,
      VPM_ST_DONE = 2'b11
   } vpm_state_t;
endpackage

// *** hdl/vpm_plane_path.sv ***
// vga planar memory path: registers, address chaining, write and read datapath
`timescale 1ns/1ps
module vpm_plane_path (
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [15:0] reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   output logic      [31:0] reg_rdata_out,
   output logic             reg_rvalid_out,
   input  wire logic [19:0] gmem_base_in,
   input  wire logic        vga_req_in,
   input  wire logic        vga_we_in,
   input  wire logic [15:0] vga_addr_in,
   input  wire logic [7:0]  vga_wdata_in,
   output logic             vga_busy_out,
   output logic             vga_done_out,
   output logic      [7:0]  vga_rdata_out,
   output logic             mem_req_out,
   output logic             mem_we_out,
   output logic      [19:0] mem_addr_out,
   output logic      [3:0]  mem_plane_we_out,
   output logic      [31:0] mem_wdata_out,
   input  wire logic [31:0] mem_rdata_in,
   input  wire logic        mem_ack_in
);
   import vpm_pkg::*;

   logic [31:0] wctl_reg;
   logic [31:0] rctl_reg;
   logic [31:0] base_reg;
   logic [31:0] latch_reg;
   logic [31:0] latch_next;
   vpm_state_t  state_reg;
   vpm_state_t  state_next;
   logic [1:0]  rd_plane_reg;
   logic [15:0] off_reg;

   // field views
   wire [3:0] map_mask   = wctl_reg[VPM_WR_MAP_LSB +: 4];
   wire       wmode3     = wctl_reg[VPM_WR_MODE3];
   wire       wmode2     = wctl_reg[VPM_WR_MODE2];
   wire [2:0] rot_count  = wctl_reg[VPM_WR_ROT_LSB +: 3];
   wire [3:0] setreset_enable = wctl_reg[VPM_WR_SEN_LSB +: 4];
   wire [3:0] setreset_value  = wctl_reg[VPM_WR_SVAL_LSB +: 4];
   wire [7:0] bit_mask   = wctl_reg[VPM_WR_MASK_LSB +: 8];
   wire [1:0] rd_sel     = rctl_reg[VPM_RD_PLANE_LSB +: 2];
   wire       force_addr_fifteen_low = rctl_reg[VPM_RD_FRC15];
   wire       packed_quad_chain      = rctl_reg[VPM_RD_PACK];
   wire       quad_chain_mode        = rctl_reg[VPM_RD_QUAD];
   wire       page_bit   = rctl_reg[VPM_RD_PAGE];
   wire       oe_chain   = rctl_reg[VPM_RD_OE];
   wire       wch2       = rctl_reg[VPM_RD_WCH2];
   wire       rch2       = rctl_reg[VPM_RD_RCH2];
   wire       rd_mode    = rctl_reg[VPM_RD_MODE];
   wire [3:0] cmp_mask   = rctl_reg[VPM_RD_CMSK_LSB +: 4];
   wire [3:0] cmp_color  = rctl_reg[VPM_RD_CCOL_LSB +: 4];
   wire [5:0] rd_base    = base_reg[VPM_BASE_RD_LSB +: 6];
   wire [5:0] wr_base    = base_reg[VPM_BASE_WR_LSB +: 6];

   // register decode
   wire sel_wctl  = reg_addr_in == VPM_OFF_WRITE_CTL;
   wire sel_rctl  = reg_addr_in == VPM_OFF_READ_CTL;
   wire sel_base  = reg_addr_in == VPM_OFF_BASE;
   wire sel_latch = reg_addr_in == VPM_OFF_LATCH;
   wire [31:0] reg_rd_mux = sel_wctl  ? wctl_reg :
                            sel_rctl  ? rctl_reg :
                            sel_base  ? base_reg :
                            sel_latch ? latch_reg : 32'h00000000;

   // request acceptance and addressing
   wire accept = vga_req_in && (state_reg == VPM_ST_IDLE);
   wire ch2    = !quad_chain_mode && (vga_we_in ? wch2 : rch2);
   wire [15:0] addr_f   = force_addr_fifteen_low ? {1'b0, vga_addr_in[14:0]} :
                          vga_addr_in;
   wire [15:0] addr_pk  = packed_quad_chain ? {2'b00, addr_f[15:2]} : addr_f;
   wire [15:0] addr_pre = quad_chain_mode ? addr_pk : addr_f;
   // page bit takes over a0 after chaining so odd/even pages stay apart
   wire [15:0] off_next = oe_chain ? {addr_pre[15:1], page_bit} : addr_pre;
   wire [3:0]  quad_en  = VPM_PLANE0 << addr_f[1:0];
   wire [3:0]  chain_en = quad_chain_mode ? quad_en :
                          ch2 ? (addr_f[0] ? VPM_ODD_PLANES : VPM_EVEN_PLANES) :
                          VPM_ALL_PLANES;
   wire [3:0]  plane_we_next = map_mask & chain_en;
   wire [1:0]  rd_plane_next = quad_chain_mode ? addr_f[1:0] :
                               ch2 ? {rd_sel[1], addr_f[0]} : rd_sel;
   wire [5:0]  win_base = vga_we_in ? wr_base : rd_base;
   wire [19:0] win_addr = {win_base, {VPM_BASE_SHIFT{1'b0}}};
   wire [19:0] mem_addr_next = gmem_base_in + win_addr + {4'h0, off_next};

   // write datapath
   wire [15:0] rot_wide = {vga_wdata_in, vga_wdata_in} >> rot_count;
   wire [7:0]  rot_data = rot_wide[7:0];
   wire [7:0]  eff_mask = wmode3 ? (bit_mask & rot_data) : bit_mask;
   wire [31:0] wdata_next;
   // read datapath
   wire [7:0]  cmp_byte;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_plane
         wire [7:0] src = wmode3 ? {8{setreset_value[gi]}} :
                          wmode2 ? {8{vga_wdata_in[gi]}} :
                          setreset_enable[gi] ? {8{setreset_value[gi]}} :
                          rot_data;
         assign wdata_next[8*gi +: 8] = (src & eff_mask) |
                                        (latch_reg[8*gi +: 8] & ~eff_mask);
      end
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_cmp
         wire [3:0] pix = {mem_rdata_in[24+gi], mem_rdata_in[16+gi],
                           mem_rdata_in[8+gi], mem_rdata_in[gi]};
         assign cmp_byte[gi] = ((pix ^ cmp_color) & cmp_mask) == 4'h0;
      end
   endgenerate

   wire [7:0] plane_byte = mem_rdata_in[8*rd_plane_reg +: 8];
   wire [7:0] rd_byte    = rd_mode ? cmp_byte : plane_byte;
   wire       rd_land    = (state_reg == VPM_ST_WAIT) && mem_ack_in && !mem_we_out;

   // a fetch landing beats a software latch write in the same cycle
   assign latch_next = rd_land ? mem_rdata_in :
                       (reg_wr_in && sel_latch) ? reg_wdata_in : latch_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         VPM_ST_IDLE: begin
            if (vga_req_in) begin
               state_next = VPM_ST_WAIT;
            end
         end
         VPM_ST_WAIT: begin
            if (mem_ack_in) begin
               state_next = VPM_ST_DONE;
            end
         end
         VPM_ST_DONE: begin
            state_next = VPM_ST_IDLE;
         end
         default: begin
            state_next = VPM_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         wctl_reg  <= VPM_WRITE_CTL_RST;
         rctl_reg  <= VPM_READ_CTL_RST;
         base_reg  <= VPM_BASE_RST;
         latch_reg <= VPM_LATCH_RST;
      end else begin
         // reserved bits are dropped so they always read back zero
         if (reg_wr_in && sel_wctl) begin
            wctl_reg <= reg_wdata_in & VPM_WR_USED;
         end
         if (reg_wr_in && sel_rctl) begin
            rctl_reg <= reg_wdata_in & VPM_RD_USED;
         end
         if (reg_wr_in && sel_base) begin
            base_reg <= reg_wdata_in & VPM_BASE_USED;
         end
         latch_reg <= latch_next;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         reg_rdata_out  <= 32'h00000000;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rdata_out  <= reg_rd_in ? reg_rd_mux : 32'h00000000;
         reg_rvalid_out <= reg_rd_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         state_reg        <= VPM_ST_IDLE;
         vga_busy_out     <= 1'b0;
         vga_done_out     <= 1'b0;
         vga_rdata_out    <= 8'h00;
         mem_req_out      <= 1'b0;
         mem_we_out       <= 1'b0;
         mem_addr_out     <= 20'h00000;
         mem_plane_we_out <= 4'h0;
         mem_wdata_out    <= 32'h00000000;
         rd_plane_reg     <= 2'b00;
         off_reg          <= 16'h0000;
      end else begin
         state_reg    <= state_next;
         vga_busy_out <= state_next != VPM_ST_IDLE;
         vga_done_out <= (state_reg == VPM_ST_WAIT) && mem_ack_in;
         mem_req_out  <= accept || ((state_reg == VPM_ST_WAIT) && !mem_ack_in);
         if (rd_land) begin
            vga_rdata_out <= rd_byte;
         end
         if (accept) begin
            mem_we_out       <= vga_we_in;
            mem_addr_out     <= mem_addr_next;
            mem_plane_we_out <= vga_we_in ? plane_we_next : 4'h0;
            mem_wdata_out    <= vga_we_in ? wdata_next : 32'h00000000;
            rd_plane_reg     <= rd_plane_next;
            off_reg          <= off_next;
         end
      end
   end

   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   plane_we_gate_a: assert property ($rose(mem_req_out) && mem_we_out |->
      (mem_plane_we_out & ~$past(map_mask)) == 4'h0)
      else $error("plane enable outside map mask");
   quad_onehot_a: assert property ($rose(mem_req_out) && mem_we_out &&
      $past(quad_chain_mode) |-> $onehot0(mem_plane_we_out))
      else $error("chain 4 write hit more than one plane");
   addr_bit15_a: assert property ($rose(mem_req_out) && $past(force_addr_fifteen_low) &&
      !$past(oe_chain) |-> !off_reg[15])
      else $error("forced address bit 15 not zero");
   packed_shift_a: assert property ($rose(mem_req_out) && $past(quad_chain_mode) &&
      $past(packed_quad_chain) |-> off_reg[15:14] == 2'b00)
      else $error("packed chain 4 address not shifted");
   write_window_a: assert property (accept && vga_we_in && !oe_chain |=>
      mem_addr_out == 20'($past(gmem_base_in) + {$past(wr_base), 14'h0000} +
                          {4'h0, off_reg}))
      else $error("write window base not applied");
   read_window_a: assert property (accept && !vga_we_in |=>
      mem_addr_out == 20'($past(gmem_base_in) + {$past(rd_base), 14'h0000} +
                          {4'h0, off_reg}))
      else $error("read window base not applied");
   latch_load_a: assert property (rd_land |=> latch_reg == $past(mem_rdata_in))
      else $error("read data not latched");
   cmp_nomask_a: assert property (rd_land && rd_mode && cmp_mask == 4'h0 |=>
      vga_rdata_out == 8'hff && vga_done_out)
      else $error("empty compare mask must match all");
   mode0_read_a: assert property (rd_land && !rd_mode |=>
      vga_rdata_out == $past(mem_rdata_in[8*rd_plane_reg +: 8]))
      else $error("mode 0 returned wrong plane");
   latch_port_a: assert property (reg_rd_in && sel_latch |=>
      reg_rvalid_out && reg_rdata_out == $past(latch_reg))
      else $error("latch register readback wrong");
   req_hold_a: assert property (mem_req_out && !mem_ack_in |=> mem_req_out)
      else $error("memory request dropped before ack");
   done_pulse_a: assert property (vga_done_out |=> !vga_done_out && !vga_busy_out)
      else $error("done longer than one cycle or busy stuck");
   read_nowrite_a: assert property ($rose(mem_req_out) && !mem_we_out |->
      mem_plane_we_out == 4'h0 && mem_wdata_out == 32'h00000000)
      else $error("read issued with plane enables");
   rvalid_idle_a: assert property (!reg_rd_in |=> !reg_rvalid_out && reg_rdata_out == 32'h0)
      else $error("register read data outside read cycle");
   pair_planes_a: assert property ($rose(mem_req_out) && mem_we_out && $past(ch2) |->
      (mem_plane_we_out & ($past(vga_addr_in[0]) ? VPM_EVEN_PLANES : VPM_ODD_PLANES)) == 4'h0)
      else $error("chain 2 write hit the wrong plane pair");

   write_seen_c: cover property (accept && vga_we_in ##1 mem_req_out [*2] ##1 vga_done_out);
   read_cmp_c: cover property (rd_land && rd_mode);
   chain4_c: cover property (accept && quad_chain_mode && packed_quad_chain);
   chain2_c: cover property (accept && ch2 && oe_chain);
endmodule

// *** bench/vpm_mem_model.sv ***
// graphics memory stand-in that answers the plane path's memory requests
`timescale 1ns/1ps
module vpm_mem_model (
   input  wire logic        clk_in,
   input  wire logic        slow_in,
   input  wire logic        mem_req_in,
   input  wire logic [19:0] mem_addr_in,
   output logic      [31:0] mem_rdata_out,
   output logic             mem_ack_out
);
   logic [1:0] wait_cnt;
   initial begin
      mem_ack_out = 1'b0;
      mem_rdata_out = 32'h0;
      wait_cnt = 2'h0;
   end
   // fetched word carries its own address; off the ack the data toggles
   always @(posedge clk_in) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      if (mem_req_in && !mem_ack_out) begin
         if (!slow_in || wait_cnt == 2'h3) begin
            mem_ack_out <= 1'b1;
            mem_rdata_out <= {12'h5a5, mem_addr_in};
            wait_cnt <= 2'h0;
         end else begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
endmodule

// *** bench/tb.sv ***
// self-checking bench for the vga planar memory path
`timescale 1ns/1ps
module tb;
   import vpm_pkg::*;
   logic clk_in = 0, rst_b_in = 0, reg_wr_in = 0, reg_rd_in = 0, slow = 0;
   logic [15:0] reg_addr_in = 0, vga_addr_in = 0;
   logic [31:0] reg_wdata_in = 0, reg_rdata_out, mem_rdata_in, mem_wdata_out, cap_wd;
   logic vga_req_in = 0, vga_we_in = 0, vga_busy_out, vga_done_out;
   logic mem_req_out, mem_we_out, mem_ack_in;
   logic [7:0] vga_wdata_in = 0, vga_rdata_out;
   logic [19:0] mem_addr_out, cap_addr;
   logic [3:0] mem_plane_we_out, cap_pwe;
   logic reg_rvalid_out, cap_we;
   int bad_count = 0, check_count = 0, cyc = 0;
   always #2.5 clk_in = ~clk_in;
   vpm_plane_path dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
      .gmem_base_in(20'h01000), .vga_req_in(vga_req_in), .vga_we_in(vga_we_in),
      .vga_addr_in(vga_addr_in), .vga_wdata_in(vga_wdata_in), .vga_busy_out(vga_busy_out),
      .vga_done_out(vga_done_out), .vga_rdata_out(vga_rdata_out),
      .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
      .mem_plane_we_out(mem_plane_we_out), .mem_wdata_out(mem_wdata_out),
      .mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in));
   vpm_mem_model mem_u (.clk_in(clk_in), .slow_in(slow), .mem_req_in(mem_req_out),
      .mem_addr_in(mem_addr_out), .mem_rdata_out(mem_rdata_in), .mem_ack_out(mem_ack_in));
   always @(posedge clk_in) begin
      if (mem_req_out && mem_ack_in) begin
         cap_addr <= mem_addr_out;
         cap_pwe <= mem_plane_we_out;
         cap_wd <= mem_wdata_out;
         cap_we <= mem_we_out;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_w(input logic [15:0] a, input logic [31:0] d);
      @(negedge clk_in);
      {reg_wr_in, reg_addr_in, reg_wdata_in} = {1'b1, a, d};
      @(negedge clk_in);
      reg_wr_in = 0;
   endtask
   task automatic reg_r(input logic [15:0] a, input logic [31:0] exp);
      @(negedge clk_in);
      {reg_rd_in, reg_addr_in} = {1'b1, a};
      @(negedge clk_in);
      reg_rd_in = 0;
      chk({31'h0, reg_rvalid_out}, 32'h1);
      chk(reg_rdata_out, exp);
   endtask
   // request held high until done, so busy-time refusals are exercised too
   task automatic vga(input logic we, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge clk_in);
      {vga_req_in, vga_we_in, vga_addr_in, vga_wdata_in} = {1'b1, we, a, d};
      @(negedge clk_in);
      chk({31'h0, vga_busy_out}, 32'h1);
      while (vga_done_out !== 1'b1 && n < 40) begin
         @(negedge clk_in);
         n++;
      end
      vga_req_in = 0;
      chk({31'h0, vga_done_out}, 32'h1);
   endtask
   function automatic logic [31:0] wr_exp(input logic [31:0] c, input logic [7:0] d,
                                          input logic [31:0] l);
      logic [7:0] r, m, s;
      logic [15:0] dd;
      dd = {d, d} >> c[18:16];
      r = dd[7:0];
      m = c[20] ? (c[7:0] & r) : c[7:0];
      for (int p = 0; p < 4; p++) begin
         s = c[20] ? {8{c[8+p]}} : c[19] ? {8{d[p]}} : c[12+p] ? {8{c[8+p]}} : r;
         wr_exp[8*p+:8] = (s & m) | (l[8*p+:8] & ~m);
      end
   endfunction
   task automatic regs_test();
      reg_r(VPM_OFF_READ_CTL, 32'h0);
      reg_r(VPM_OFF_LATCH, 32'h0);
      reg_w(VPM_OFF_WRITE_CTL, '1);
      reg_w(VPM_OFF_READ_CTL, '1);
      reg_w(VPM_OFF_BASE, '1);
      reg_w(VPM_OFF_LATCH, 32'h11223344);
      reg_r(VPM_OFF_WRITE_CTL, 32'h0f1fffff);
      reg_r(VPM_OFF_READ_CTL, 32'h0003ffff);
      reg_r(VPM_OFF_BASE, 32'h00003f3f);
      reg_r(VPM_OFF_LATCH, 32'h11223344);
      reg_r(16'h8148, 32'h0);
      $display("register test finished");
   endtask
   task automatic write_test();
      logic [31:0] c [3];
      c = '{32'h0f13_31f0, 32'h0608_00ff, 32'h0f1a_000f};
      reg_w(VPM_OFF_BASE, 32'h0000_0201);
      reg_w(VPM_OFF_READ_CTL, 32'h0);
      foreach (c[i]) begin
         reg_w(VPM_OFF_WRITE_CTL, c[i]);
         vga(1'b1, 16'h0040, 8'h3c);
         chk(cap_wd, wr_exp(c[i], 8'h3c, 32'h11223344));
         chk({28'h0, cap_pwe}, {28'h0, c[i][27:24]});
         chk({12'h0, cap_addr}, 32'h05040);
         chk({31'h0, cap_we}, 32'h1);
      end
      reg_w(VPM_OFF_READ_CTL, 32'h0000_6400);
      vga(1'b1, 16'h0006, 8'h01);
      chk({28'h0, cap_pwe}, 32'h4);
      chk({12'h0, cap_addr}, 32'h05001);
      reg_w(VPM_OFF_READ_CTL, 32'h0000_0400);
      vga(1'b1, 16'h0003, 8'h01);
      chk({28'h0, cap_pwe}, 32'ha);
      reg_w(VPM_OFF_READ_CTL, 32'h0000_8800);
      vga(1'b1, 16'h8011, 8'h01);
      chk({12'h0, cap_addr}, 32'h05010);
      $display("write test finished");
   endtask
   task automatic rd(input logic [31:0] c, input logic [15:0] a, input logic [7:0] e);
      reg_w(VPM_OFF_READ_CTL, c);
      vga(1'b0, a, 8'h00);
      chk({24'h0, vga_rdata_out}, {24'h0, e});
      chk({31'h0, cap_we}, 32'h0);
   endtask
   task automatic read_test();
      slow = 1;
      rd(32'h0001_0000, 16'h0020, 8'h90);
      chk({12'h0, cap_addr}, 32'h09020);
      reg_r(VPM_OFF_LATCH, 32'h5a509020);
      rd(32'h0000_0131, 16'h0020, 8'h20);
      slow = 0;
      rd(32'h0000_0100, 16'h0020, 8'hff);
      rd(32'h0002_0200, 16'h0021, 8'h5a);
      rd(32'h0002_0200, 16'h0020, 8'h50);
      rd(32'h0000_2200, 16'h0002, 8'h50);
      $display("read test finished");
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         finish_test();
      end
   end
   initial begin
      repeat (4) @(negedge clk_in);
      rst_b_in = 1;
      regs_test();
      write_test();
      read_test();
      finish_test();
   end
endmodule
